// *** kpi_pkg.sv ***
// Package: register map, field positions and reset values of the keyboard pin interrupt
package kpi_pkg;
  localparam int unsigned KPI_PINS = 6;

  // Register byte addresses
  localparam logic [7:0] KPI_ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] KPI_ADDR_PIN_ENABLE     = 8'h04;
  localparam logic [7:0] KPI_ADDR_PIN_POLARITY   = 8'h08;

  // Status/control field positions
  localparam int unsigned KPI_BIT_SENSITIVITY = 0;
  localparam int unsigned KPI_BIT_MASK        = 1;
  localparam int unsigned KPI_BIT_ACK         = 2;
  localparam int unsigned KPI_BIT_PENDING     = 3;

  // Reset values
  localparam logic                KPI_RST_SENSITIVITY = 1'b0;
  localparam logic                KPI_RST_MASK        = 1'b0;
  localparam logic [KPI_PINS-1:0] KPI_RST_ENABLES     = 6'h00;
  localparam logic [KPI_PINS-1:0] KPI_RST_POLARITIES  = 6'h00;

  typedef enum logic [1:0] {
    KPI_IDLE,
    KPI_LATCHED
  } kpi_latch_type;
endpackage : kpi_pkg

// *** kpi_sync.sv ***
// Three-flop synchroniser with agreement filter for the key pins
`timescale 1ns/1ps
module kpi_sync
  import kpi_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // Pins and filtered level
  input  wire logic [KPI_PINS-1:0] pin_async,
  output logic      [KPI_PINS-1:0] pin_level
);
  genvar g;
  generate
    for (g = 0; g < KPI_PINS; g++) begin : g_pin
      // Per-pin flops so that each variable has one writing process
      logic stage1;
      logic stage2;
      logic stage3;
      logic level;
      wire  agree = (stage2 == stage3);
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          level  <= 1'b0;
        end else begin
          stage1 <= pin_async[g];
          stage2 <= stage1;
          stage3 <= stage2;
          if (agree) begin
            level <= stage3;
          end
        end
      end
      assign pin_level[g] = level;
    end
  endgenerate
endmodule // kpi_sync

// *** kpi_detect.sv ***
// Per-pin polarity, enable, assertion level and edge detection
`timescale 1ns/1ps
module kpi_detect
  import kpi_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // Configuration
  input  wire logic [KPI_PINS-1:0] enables,
  input  wire logic [KPI_PINS-1:0] polarities,
  // Synchronised levels
  input  wire logic [KPI_PINS-1:0] pin_level,
  // Results
  output logic      [KPI_PINS-1:0] asserted,
  output logic      [KPI_PINS-1:0] edge_seen
);
  genvar g;
  generate
    for (g = 0; g < KPI_PINS; g++) begin : g_pin
      // Polarity 1 means high/rising, 0 means low/falling
      logic prev_asserted;
      wire  raw = polarities[g] ? pin_level[g] : ~pin_level[g];
      assign asserted[g]  = enables[g] & raw;
      assign edge_seen[g] = asserted[g] & ~prev_asserted;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          prev_asserted <= 1'b0;
        end else begin
          prev_asserted <= asserted[g];
        end
      end
    end
  endgenerate
endmodule // kpi_detect

// *** kpi_top.sv ***
// Keyboard pin interrupt: APB registers, request latch, wake and pull control
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module kpi_top
  import kpi_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // System
  input  wire logic                break_state,
  input  wire logic                break_clear_permit,
  input  wire logic                vector_fetch,
  // Key pins
  input  wire logic [KPI_PINS-1:0] key_input_pins,
  output logic      [KPI_PINS-1:0] pull_up_en,
  output logic      [KPI_PINS-1:0] pull_down_en,
  // Processor
  output logic                     key_irq,
  output logic                     wake_request
);
  logic                key_sensitivity_select;
  logic                key_request_mask;
  logic [KPI_PINS-1:0] key_pin_enables;
  logic [KPI_PINS-1:0] key_pin_polarities;
  kpi_latch_type       latch_state;
  kpi_latch_type       next_latch_state;
  logic                ack_seen;
  logic                next_ack_seen;
  logic [KPI_PINS-1:0] pin_level;
  logic [KPI_PINS-1:0] asserted;
  logic [KPI_PINS-1:0] edge_seen;

  kpi_sync u_sync (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .pin_async (key_input_pins),
    .pin_level (pin_level)
  );

  kpi_detect u_detect (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .enables    (key_pin_enables),
    .polarities (key_pin_polarities),
    .pin_level  (pin_level),
    .asserted   (asserted),
    .edge_seen  (edge_seen)
  );

  // Bus decode
  wire access      = psel & penable;
  wire wr          = access & pwrite;
  wire sel_sc      = (paddr == KPI_ADDR_STATUS_CONTROL);
  wire sel_en      = (paddr == KPI_ADDR_PIN_ENABLE);
  wire sel_pol     = (paddr == KPI_ADDR_PIN_POLARITY);
  wire mapped      = sel_sc | sel_en | sel_pol;
  wire wr_sc       = wr & sel_sc;
  wire wr_en       = wr & sel_en;
  wire wr_pol      = wr & sel_pol;

  // Software acknowledge obeys the break permission; vector fetch clears regardless
  wire clear_ok    = ~break_state | break_clear_permit;
  wire sw_ack      = wr_sc & pwdata[KPI_BIT_ACK] & clear_ok;
  wire any_ack     = sw_ack | vector_fetch;
  wire any_assert  = |asserted;
  // An edge counts only if no other enabled pin was already asserted
  wire [KPI_PINS-1:0] others_held = asserted & ~edge_seen;
  wire edge_event  = (|edge_seen) & ~(|others_held);
  wire set_event   = key_sensitivity_select ? (edge_event | any_assert)
                                            : edge_event;
  wire pending     = (latch_state == KPI_LATCHED);

  // Latch next state; a new set wins over a clear in the same cycle
  always_comb begin
    next_latch_state = latch_state;
    next_ack_seen    = ack_seen;
    case (latch_state)
      KPI_IDLE: begin
        next_ack_seen = 1'b0;
        if (set_event) begin
          next_latch_state = KPI_LATCHED;
        end
      end
      KPI_LATCHED: begin
        if (!key_sensitivity_select) begin
          next_ack_seen = 1'b0;
          if (any_ack && !edge_event) begin
            next_latch_state = KPI_IDLE;
          end
        end else begin
          if (any_ack) begin
            next_ack_seen = 1'b1;
          end
          if ((any_ack || ack_seen) && !any_assert && !edge_event) begin
            next_latch_state = KPI_IDLE;
            next_ack_seen    = 1'b0;
          end
        end
      end
      default: begin
        next_latch_state = KPI_IDLE;
        next_ack_seen    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      latch_state <= KPI_IDLE;
      ack_seen    <= 1'b0;
    end else begin
      latch_state <= next_latch_state;
      ack_seen    <= next_ack_seen;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      key_sensitivity_select <= KPI_RST_SENSITIVITY;
      key_request_mask       <= KPI_RST_MASK;
      key_pin_enables        <= KPI_RST_ENABLES;
      key_pin_polarities     <= KPI_RST_POLARITIES;
    end else begin
      if (wr_sc) begin
        key_sensitivity_select <= pwdata[KPI_BIT_SENSITIVITY];
        key_request_mask       <= pwdata[KPI_BIT_MASK];
      end
      if (wr_en) begin
        key_pin_enables <= pwdata[KPI_PINS-1:0];
      end
      if (wr_pol) begin
        key_pin_polarities <= pwdata[KPI_PINS-1:0];
      end
    end
  end

  // Read data; acknowledge and reserved bits read 0
  wire [31:0] rd_sc  = {28'h0000000, pending, 1'b0, key_request_mask,
                        key_sensitivity_select};
  wire [31:0] rd_en  = {26'h0, key_pin_enables};
  wire [31:0] rd_pol = {26'h0, key_pin_polarities};
  wire [31:0] rd_mux = sel_sc ? rd_sc : sel_en ? rd_en : sel_pol ? rd_pol : 32'h00000000;

  // Request, wake and pull outputs, all registered
  wire irq_next = pending & ~key_request_mask;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata       <= 32'h00000000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      key_irq      <= 1'b0;
      wake_request <= 1'b0;
      pull_up_en   <= 6'h00;
      pull_down_en <= 6'h00;
    end else begin
      pready       <= psel & ~penable;
      pslverr      <= psel & ~penable & ~mapped;
      prdata       <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
      key_irq      <= irq_next;
      wake_request <= irq_next;
      pull_up_en   <= key_pin_enables & ~key_pin_polarities;
      pull_down_en <= key_pin_enables & key_pin_polarities;
    end
  end
endmodule // kpi_top

// *** kpi_checker.sv ***
// Checker: bus and output relations of the key pin interrupt
`timescale 1ns/1ps
module kpi_checker
  import kpi_pkg::*;
(
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                nrst,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Pins and processor
  input wire logic [KPI_PINS-1:0] pull_up_en,
  input wire logic [KPI_PINS-1:0] pull_down_en,
  input wire logic                key_irq,
  input wire logic                wake_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire rd_done = pready && !pwrite;
  wire unmapped = !(paddr inside {KPI_ADDR_STATUS_CONTROL, KPI_ADDR_PIN_ENABLE,
                                  KPI_ADDR_PIN_POLARITY});
  property p_wake; wake_request == key_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap; psel && !penable && unmapped |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_ack0;
    rd_done && paddr == KPI_ADDR_STATUS_CONTROL |-> !prdata[KPI_BIT_ACK] && !prdata[31:4];
  endproperty
  a_ack0: assert property (p_ack0) else $error("ack bit read back");
  property p_rsv;
    rd_done && paddr == KPI_ADDR_PIN_ENABLE |-> prdata[31:KPI_PINS] == '0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_pull; (pull_up_en & pull_down_en) == '0; endproperty
  a_pull: assert property (p_pull) else $error("both pulls on");
  property p_rst; $rose(nrst) |-> !key_irq [*2]; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(key_irq));
  c_ack: cover property (pready && pwrite && paddr == KPI_ADDR_STATUS_CONTROL
                         && pwdata[KPI_BIT_ACK]);
endmodule // kpi_checker
bind kpi_top kpi_checker u_chk (.*);

// *** kpi_keypad.sv ***
// Keypad model: pressed keys driven, released keys follow pull or float
`timescale 1ns/1ps
module kpi_keypad
  import kpi_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic [KPI_PINS-1:0] drv,
  input  wire logic [KPI_PINS-1:0] den,
  input  wire logic [KPI_PINS-1:0] pu,
  input  wire logic [KPI_PINS-1:0] pd,
  output logic      [KPI_PINS-1:0] pins
);
  logic [KPI_PINS-1:0] flt = '0;
  // Unpulled open lines wander
  always @(posedge sys_clk) flt <= ~flt;
  always_comb
    for (int i = 0; i < KPI_PINS; i++)
      pins[i] = den[i] ? drv[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : flt[i];
endmodule // kpi_keypad

// *** keyboard_pin_interrupt_tb.sv ***
// Testbench: registers, latching, mask, break and reset of the key unit
`timescale 1ns/1ps
module keyboard_pin_interrupt_tb;
  import kpi_pkg::*;
  localparam logic [7:0] SC = KPI_ADDR_STATUS_CONTROL;
  localparam logic [7:0] EN = KPI_ADDR_PIN_ENABLE;
  localparam logic [7:0] PO = KPI_ADDR_PIN_POLARITY;
  localparam logic [32:0] SEN = 33'h1 << KPI_BIT_SENSITIVITY;
  localparam logic [32:0] MSK = 33'h1 << KPI_BIT_MASK;
  localparam logic [32:0] ACK = 33'h1 << KPI_BIT_ACK;
  localparam logic [32:0] PEND = 33'h1 << KPI_BIT_PENDING;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic break_state = 0, break_clear_permit = 0, vector_fetch = 0;
  logic pready, pslverr, key_irq, wake_request;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [KPI_PINS-1:0] key_input_pins, pull_up_en, pull_down_en, pol;
  logic [KPI_PINS-1:0] drv = '0, den = '0;
  logic [32:0] expq[$];
  int errors = 0, checks = 0, cyc = 0;
  integer seed = 32'h91b9;
  kpi_top dut (.*);
  kpi_keypad u_pad (.sys_clk(sys_clk), .drv(drv), .den(den), .pu(pull_up_en),
                    .pd(pull_down_en), .pins(key_input_pins));
  initial forever #5 sys_clk = ~sys_clk;
  task chk(string n, logic [32:0] e, logic [32:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read results compared against the oldest note
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", expq.pop_front(), {pslverr, prdata});
  end
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(logic [7:0] a, logic [32:0] d);
    apb(1, a, d[31:0]);
  endtask
  task rd(logic [7:0] a, logic [32:0] e);
    expq.push_back(e);
    apb(0, a, 0);
  endtask
  task key(int i, logic on);
    drv[i] <= pol[i];
    den[i] <= on;
    repeat (8) @(posedge sys_clk);
  endtask
  task irq(logic e);
    chk("irq", {32'h0, e}, {32'h0, key_irq});
    chk("wake", {32'h0, e}, {32'h0, wake_request});
  endtask
  initial begin
    pol = KPI_PINS'($random(seed));
    repeat (8) @(posedge sys_clk);
    nrst <= 1;
    rd(SC, 0);
    rd(EN, 0);
    rd(PO, 0);
    rd(8'h0c, 33'h1_0000_0000);
    wr(PO, {27'h0, pol});
    wr(EN, 33'h3f);
    repeat (8) @(posedge sys_clk);
    wr(SC, ACK);
    rd(PO, {27'h0, pol});
    rd(EN, 33'h3f);
    chk("pull_up", {27'h0, ~pol}, {27'h0, pull_up_en});
    chk("pull_dn", {27'h0, pol}, {27'h0, pull_down_en});
    key(0, 1);
    irq(1);
    rd(SC, PEND);
    wr(SC, MSK);
    repeat (2) @(posedge sys_clk);
    irq(0);
    rd(SC, PEND | MSK);
    wr(SC, MSK | ACK);
    rd(SC, MSK);
    key(1, 1);
    rd(SC, MSK);
    key(0, 0);
    key(1, 0);
    wr(EN, 33'h3e);
    key(0, 1);
    rd(SC, MSK);
    wr(SC, 0);
    key(2, 1);
    irq(1);
    @(posedge sys_clk) vector_fetch <= 1;
    @(posedge sys_clk) vector_fetch <= 0;
    rd(SC, 0);
    key(2, 0);
    key(3, 1);
    break_state <= 1;
    wr(SC, ACK);
    rd(SC, PEND);
    break_clear_permit <= 1;
    wr(SC, ACK);
    break_state <= 0;
    break_clear_permit <= 0;
    rd(SC, 0);
    wr(SC, SEN);
    rd(SC, SEN | PEND);
    wr(SC, SEN | ACK);
    rd(SC, SEN | PEND);
    key(3, 0);
    rd(SC, SEN);
    key(4, 1);
    key(4, 0);
    rd(SC, SEN | PEND);
    wr(SC, SEN | ACK);
    rd(SC, SEN);
    key(5, 1);
    irq(1);
    nrst <= 0;
    @(posedge sys_clk);
    nrst <= 1;
    rd(SC, 0);
    stop_test();
  end
endmodule // keyboard_pin_interrupt_tb
